/* src/orn_ctl.sv */
// Purpose: register bank for over-range thresholds, period and oscillator preset selection
// Assumes: Avalon-MM slave with waitrequest, byte address, one register per aligned word
// Notes: every access answers on its second cycle while ce_i is high; unmapped reads return zero

`timescale 1ns/1ps

module orn_ctl #(
  parameter int BASE_PERIOD = orn_pkg::BASE_PERIOD
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire orn_pkg::orn_avs_req_t avs_req_i,
  output logic [orn_pkg::DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire orn_pkg::orn_smp_t smp_i,
  output orn_pkg::orn_smp_t smp_o,
  output logic [1:0] range_flag_bits_o,
  input wire logic [orn_pkg::PRESET_W-1:0] preset_select_pins_i,
  output orn_pkg::orn_preset_t active_preset_o,
  output logic [orn_pkg::DIV_W-1:0] rational_step_divisor_o
);
  import orn_pkg::*;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [THR_W-1:0] range_limit_i_ff;
  logic [THR_W-1:0] range_limit_q_ff;
  logic [PER_W-1:0] range_watch_period_ff;
  logic preset_source_ctl_ff;
  logic [PRESET_W-1:0] preset_choice_ff;
  logic [DIV_W-1:0] rational_step_divisor_ff;
  logic [FREQ_W-1:0] preset_freq_word_ff [N_PRESET];
  logic [PHASE_W-1:0] preset_phase_word_ff [N_PRESET];
  logic [DLY_W-1:0] preset_delay_setting_ff [N_PRESET];
  logic ack_ff;
  logic [DATA_W-1:0] readdata_ff;
  orn_preset_t active_ff;
  orn_preset_t nxt_active;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire logic [IDX_W-1:0] idx = avs_req_i.address[ADDR_W-1:IDX_LSB];
  wire logic req = avs_req_i.read | avs_req_i.write;
  // write lands on the single edge where waitrequest is low
  wire logic wr_commit = avs_req_i.write & ack_ff;
  wire logic be0 = avs_req_i.byteenable[0];
  wire logic [DATA_W-1:0] wd = avs_req_i.writedata;
  wire logic [PRESET_W-1:0] slot = idx[PRESET_W-1:0];
  wire logic [IDX_W-PRESET_W-1:0] grp = idx[IDX_W-1:PRESET_W];
  wire logic hit_freq = grp == IDX_FREQ_BASE[IDX_W-1:PRESET_W];
  wire logic hit_phase = grp == IDX_PHASE_BASE[IDX_W-1:PRESET_W];
  wire logic hit_dly = grp == IDX_DLY_BASE[IDX_W-1:PRESET_W];
  wire logic sel_limit_i = idx == IDX_LIMIT_I;
  wire logic sel_limit_q = idx == IDX_LIMIT_Q;
  wire logic sel_period = idx == IDX_PERIOD;
  wire logic sel_src = idx == IDX_SRC;
  wire logic sel_choice = idx == IDX_CHOICE;
  wire logic sel_div_lo = idx == IDX_DIV_LO;
  wire logic sel_div_hi = idx == IDX_DIV_HI;
  wire logic wr_byte = wr_commit & be0;

  assign avs_waitrequest_o = req & ~ack_ff;
  assign avs_readdata_o = readdata_ff;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rd_word;

  always_comb begin
    rd_word = RD_ZERO;
    if (sel_limit_i) begin
      rd_word = DATA_W'(range_limit_i_ff);
    end else if (sel_limit_q) begin
      rd_word = DATA_W'(range_limit_q_ff);
    end else if (sel_period) begin
      rd_word = DATA_W'(range_watch_period_ff);
    end else if (sel_src) begin
      rd_word = DATA_W'(preset_source_ctl_ff);
    end else if (sel_choice) begin
      rd_word = DATA_W'(preset_choice_ff);
    end else if (sel_div_lo) begin
      rd_word = DATA_W'(rational_step_divisor_ff[BYTE_W-1:0]);
    end else if (sel_div_hi) begin
      rd_word = DATA_W'(rational_step_divisor_ff[DIV_W-1:BYTE_W]);
    end else if (hit_freq) begin
      rd_word = preset_freq_word_ff[slot];
    end else if (hit_phase) begin
      rd_word = DATA_W'(preset_phase_word_ff[slot]);
    end else if (hit_dly) begin
      rd_word = DATA_W'(preset_delay_setting_ff[slot]);
    end
  end

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_ff <= 1'b0;
      readdata_ff <= RD_ZERO;
    end else if (ce_i) begin
      ack_ff <= req & ~ack_ff;
      if (avs_req_i.read & ~ack_ff) begin
        readdata_ff <= rd_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // scalar registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      range_limit_i_ff <= RST_LIMIT_I;
      range_limit_q_ff <= RST_LIMIT_Q;
      range_watch_period_ff <= RST_PERIOD;
      preset_source_ctl_ff <= RST_SRC;
      preset_choice_ff <= RST_CHOICE;
    end else if (ce_i && wr_byte) begin
      if (sel_limit_i) begin
        range_limit_i_ff <= wd[THR_W-1:0];
      end
      if (sel_limit_q) begin
        range_limit_q_ff <= wd[THR_W-1:0];
      end
      if (sel_period) begin
        range_watch_period_ff <= wd[PER_W-1:0];
      end
      if (sel_src) begin
        preset_source_ctl_ff <= wd[SRC_BIT];
      end
      if (sel_choice) begin
        preset_choice_ff <= wd[PRESET_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // shared step divisor
  // ----------------------------------------------------------------
  // no clamp at 8192: larger values stay legal, only spur performance suffers
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rational_step_divisor_ff <= RST_DIV;
    end else if (ce_i && wr_byte) begin
      if (sel_div_lo) begin
        rational_step_divisor_ff[BYTE_W-1:0] <= wd[BYTE_W-1:0];
      end
      if (sel_div_hi) begin
        rational_step_divisor_ff[DIV_W-1:BYTE_W] <= wd[BYTE_W-1:0];
      end
    end
  end

  assign rational_step_divisor_o = rational_step_divisor_ff;

  // ----------------------------------------------------------------
  // per-preset words
  // ----------------------------------------------------------------
  wire logic [DATA_W-1:0] freq_old = preset_freq_word_ff[slot];
  wire logic [DATA_W-1:0] phase_old = DATA_W'(preset_phase_word_ff[slot]);
  wire logic [DATA_W-1:0] freq_new = orn_merge(freq_old, wd, avs_req_i.byteenable);
  wire logic [DATA_W-1:0] phase_new = orn_merge(phase_old, wd, avs_req_i.byteenable);

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int p = 0; p < N_PRESET; p++) begin
        preset_freq_word_ff[p] <= RST_FREQ;
        preset_phase_word_ff[p] <= RST_PHASE;
        preset_delay_setting_ff[p] <= RST_DLY;
      end
    end else if (ce_i && wr_commit) begin
      if (hit_freq) begin
        preset_freq_word_ff[slot] <= freq_new;
      end
      if (hit_phase) begin
        preset_phase_word_ff[slot] <= phase_new[PHASE_W-1:0];
      end
      if (hit_dly && be0) begin
        preset_delay_setting_ff[slot] <= wd[DLY_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // active preset
  // ----------------------------------------------------------------
  // choice register is ignored while pins are the source
  wire logic [PRESET_W-1:0] cur_preset = preset_source_ctl_ff ? preset_choice_ff : preset_select_pins_i;

  always_comb begin
    nxt_active.index = cur_preset;
    nxt_active.freq = preset_freq_word_ff[cur_preset];
    nxt_active.phase = preset_phase_word_ff[cur_preset];
    nxt_active.delay = preset_delay_setting_ff[cur_preset];
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      active_ff <= '0;
    end else if (ce_i) begin
      active_ff <= nxt_active;
    end
  end

  assign active_preset_o = active_ff;

  // ----------------------------------------------------------------
  // over-range monitor
  // ----------------------------------------------------------------
  orn_range_monitor #(
    .BASE_PERIOD(BASE_PERIOD)
  ) u_monitor (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .smp_i(smp_i),
    .limit_i_i(range_limit_i_ff),
    .limit_q_i(range_limit_q_ff),
    .period_sel_i(range_watch_period_ff),
    .smp_o(smp_o),
    .range_flag_bits_o(range_flag_bits_o)
  );

endmodule : orn_ctl

/* src/orn_pkg.sv */
// Purpose: shared constants, types and helpers for the over-range and preset control block
// Assumes: 32-bit Avalon-MM register bus, one register per aligned word
// Notes: register byte address is four times the register index

package orn_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int IDX_W = 10;
  localparam int IDX_LSB = 2;
  localparam int SMP_W = 15;
  localparam int THR_W = 8;
  localparam int THR_SHIFT = SMP_W - 1 - THR_W;
  localparam int PER_W = 3;
  localparam int PRESET_W = 3;
  localparam int N_PRESET = 8;
  localparam int FREQ_W = 32;
  localparam int PHASE_W = 16;
  localparam int DLY_W = 4;
  localparam int DIV_W = 16;
  localparam int BYTE_W = 8;
  localparam int FLAG_I = 0;
  localparam int FLAG_Q = 1;
  localparam int SRC_BIT = 0;
  localparam int BASE_PERIOD = 16;

  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_LIMIT_I = 10'h206;
  localparam logic [IDX_W-1:0] IDX_LIMIT_Q = 10'h207;
  localparam logic [IDX_W-1:0] IDX_PERIOD = 10'h208;
  localparam logic [IDX_W-1:0] IDX_SRC = 10'h20C;
  localparam logic [IDX_W-1:0] IDX_CHOICE = 10'h20D;
  localparam logic [IDX_W-1:0] IDX_DIV_LO = 10'h20E;
  localparam logic [IDX_W-1:0] IDX_DIV_HI = 10'h20F;
  localparam logic [IDX_W-1:0] IDX_FREQ_BASE = 10'h220;
  localparam logic [IDX_W-1:0] IDX_PHASE_BASE = 10'h228;
  localparam logic [IDX_W-1:0] IDX_DLY_BASE = 10'h230;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [THR_W-1:0] RST_LIMIT_I = 8'hF2;
  localparam logic [THR_W-1:0] RST_LIMIT_Q = 8'hAB;
  localparam logic [PER_W-1:0] RST_PERIOD = 3'h0;
  localparam logic RST_SRC = 1'b0;
  localparam logic [PRESET_W-1:0] RST_CHOICE = 3'h0;
  localparam logic [DIV_W-1:0] RST_DIV = 16'h0000;
  localparam logic [FREQ_W-1:0] RST_FREQ = 32'hC000_0000;
  localparam logic [PHASE_W-1:0] RST_PHASE = 16'h0000;
  localparam logic [DLY_W-1:0] RST_DLY = 4'h0;
  localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
    logic [BE_W-1:0] byteenable;
  } orn_avs_req_t;

  typedef struct packed {
    logic valid;
    logic signed [SMP_W-1:0] i;
    logic signed [SMP_W-1:0] q;
  } orn_smp_t;

  typedef struct packed {
    logic [PRESET_W-1:0] index;
    logic [FREQ_W-1:0] freq;
    logic [PHASE_W-1:0] phase;
    logic [DLY_W-1:0] delay;
  } orn_preset_t;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [SMP_W-1:0] orn_abs(input logic signed [SMP_W-1:0] x);
    logic signed [SMP_W-1:0] neg;
    neg = -x;
    // most negative code wraps to its own pattern, read as unsigned full scale
    orn_abs = x[SMP_W-1] ? neg : x;
  endfunction : orn_abs

  function automatic logic orn_hit(input logic signed [SMP_W-1:0] x, input logic [THR_W-1:0] thr);
    logic [SMP_W-1:0] lvl;
    lvl = {{(SMP_W-THR_W){1'b0}}, thr} << THR_SHIFT;
    orn_hit = orn_abs(x) >= lvl;
  endfunction : orn_hit

  function automatic logic [DATA_W-1:0] orn_merge(input logic [DATA_W-1:0] old,
                                                  input logic [DATA_W-1:0] wd,
                                                  input logic [BE_W-1:0] be);
    logic [DATA_W-1:0] res;
    res = old;
    for (int b = 0; b < BE_W; b++) begin
      if (be[b]) begin
        res[b*BYTE_W +: BYTE_W] = wd[b*BYTE_W +: BYTE_W];
      end
    end
    orn_merge = res;
  endfunction : orn_merge

endpackage : orn_pkg

/* src/orn_range_monitor.sv */
// Purpose: over-range detection on i and q samples over a scalable monitoring period
// Assumes: one sample pair per cycle where valid is high
// Notes: period counts valid samples only

`timescale 1ns/1ps

module orn_range_monitor #(
  parameter int BASE_PERIOD = orn_pkg::BASE_PERIOD
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire orn_pkg::orn_smp_t smp_i,
  input wire logic [orn_pkg::THR_W-1:0] limit_i_i,
  input wire logic [orn_pkg::THR_W-1:0] limit_q_i,
  input wire logic [orn_pkg::PER_W-1:0] period_sel_i,
  output orn_pkg::orn_smp_t smp_o,
  output logic [1:0] range_flag_bits_o
);
  import orn_pkg::*;

  localparam int CNT_W = $clog2(BASE_PERIOD) + (1 << PER_W);

  // ----------------------------------------------------------------
  // period length and end
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic new_period_ff;
  logic [1:0] flag_ff;
  logic [1:0] nxt_flag;
  orn_smp_t smp_ff;
  wire logic [CNT_W-1:0] base_len = CNT_W'(BASE_PERIOD);
  wire logic [CNT_W-1:0] period_len = base_len << period_sel_i;
  // compare with >= so a shortened period ends at once instead of wrapping the counter
  wire logic period_end = cnt_ff >= (period_len - CNT_W'(1));
  wire logic [1:0] hit = {orn_hit(smp_i.q, limit_q_i), orn_hit(smp_i.i, limit_i_i)};

  assign nxt_cnt = period_end ? '0 : cnt_ff + CNT_W'(1);
  // held to end of period, first sample of a new period starts clean
  assign nxt_flag = (new_period_ff ? 2'b00 : flag_ff) | hit;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_ff <= '0;
      new_period_ff <= 1'b1;
      flag_ff <= 2'b00;
      smp_ff <= '0;
    end else if (ce_i) begin
      smp_ff <= smp_i;
      if (smp_i.valid) begin
        cnt_ff <= nxt_cnt;
        new_period_ff <= period_end;
        flag_ff <= nxt_flag;
      end
    end
  end

  assign smp_o = smp_ff;
  assign range_flag_bits_o = flag_ff;

endmodule : orn_range_monitor

/* test/orn_ctl_asserts.sv */
// Purpose: port-level checks of the over-range and preset control block
// Assumes: ce_i stays high while a bus request is pending
// Notes: bound to every orn_ctl instance
`timescale 1ns/1ps
module orn_ctl_asserts
  import orn_pkg::*;
#(
  parameter int BASE_PERIOD = 16
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire orn_avs_req_t avs_req_i,
  input wire logic [DATA_W-1:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire orn_smp_t smp_i,
  input wire orn_smp_t smp_o,
  input wire logic [1:0] range_flag_bits_o,
  input wire logic [PRESET_W-1:0] preset_select_pins_i,
  input wire orn_preset_t active_preset_o,
  input wire logic [DIV_W-1:0] rational_step_divisor_o
);
  // ----
  // properties
  // ----
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  wire req_w = avs_req_i.read | avs_req_i.write;
  wire done_w = req_w & ~avs_waitrequest_o;
  // most negative code is above every threshold, so it must always hit
  wire full_i_w = ce_i & smp_i.valid & (smp_i.i == 15'h4000);
  wire full_q_w = ce_i & smp_i.valid & (smp_i.q == 15'h4000);
  wire div_wr_w = done_w & ce_i & avs_req_i.write & avs_req_i.byteenable[0] &
                  (avs_req_i.address == {IDX_DIV_LO, 2'b00});
  chk_wait_first: assert property ($rose(req_w) |-> avs_waitrequest_o)
    else $error("new request answered without a wait cycle");
  chk_wait_once: assert property (req_w && avs_waitrequest_o && ce_i |=> !avs_waitrequest_o)
    else $error("request waited more than one cycle");
  chk_smp_delay: assert property (ce_i |=> smp_o == $past(smp_i))
    else $error("sample output not one cycle behind input");
  chk_flag_i_full: assert property (full_i_w |=> range_flag_bits_o[FLAG_I])
    else $error("full scale i sample left flag 0 clear");
  chk_flag_q_full: assert property (full_q_w |=> range_flag_bits_o[FLAG_Q])
    else $error("full scale q sample left flag 1 clear");
  chk_flag_hold: assert property (ce_i && !smp_i.valid |=> $stable(range_flag_bits_o))
    else $error("flags moved on an invalid sample");
  chk_ce_freeze: assert property (!ce_i |=> $stable(smp_o) && $stable(range_flag_bits_o) &&
                                  $stable(active_preset_o))
    else $error("outputs moved with clock enable low");
  chk_div_quiet: assert property (!avs_req_i.write |=> $stable(rational_step_divisor_o))
    else $error("divisor moved without a write");
  chk_div_low: assert property (div_wr_w |=> rational_step_divisor_o[7:0] ==
                                $past(avs_req_i.writedata[7:0]))
    else $error("divisor low byte not written");
  chk_rd_hold: assert property (!avs_req_i.read |=> $stable(avs_readdata_o))
    else $error("read data moved without a read");
  cover property (done_w && avs_req_i.write);
  cover property (done_w && avs_req_i.read);
  cover property (full_i_w);
  cover property (!ce_i);
endmodule : orn_ctl_asserts

bind orn_ctl orn_ctl_asserts #(.BASE_PERIOD(BASE_PERIOD)) orn_ctl_asserts_inst (
  .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .avs_req_i(avs_req_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .smp_i(smp_i),
  .smp_o(smp_o), .range_flag_bits_o(range_flag_bits_o), .preset_select_pins_i(preset_select_pins_i),
  .active_preset_o(active_preset_o), .rational_step_divisor_o(rational_step_divisor_o));

/* test/orn_ctl_tb_top.sv */
// Purpose: directed register, preset and over-range tests of orn_ctl
// Assumes: base period shortened to 2 valid samples
// Notes: sample and preset outputs sampled at the falling edge; bus answers taken at the rising edge
`timescale 1ns/1ps
module orn_ctl_tb_top;
  import orn_pkg::*;
  localparam int BP = 2;
  logic ref_clk_i;
  logic rst_b_i = 1'b0;
  logic ce_i = 1'b1;
  orn_avs_req_t req = '0;
  orn_smp_t smp_i = '0;
  logic [PRESET_W-1:0] pins = '0;
  logic [DATA_W-1:0] rdata;
  logic wreq;
  orn_smp_t smp_o;
  logic [1:0] flags;
  logic [1:0] fl;
  orn_preset_t act;
  logic [DIV_W-1:0] div;
  logic [DATA_W-1:0] v;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int ones;

  orn_ctl #(.BASE_PERIOD(BP)) orn_ctl_inst (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .avs_req_i(req), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .smp_i(smp_i), .smp_o(smp_o),
    .range_flag_bits_o(flags), .preset_select_pins_i(pins), .active_preset_o(act),
    .rational_step_divisor_o(div));

  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  // ----
  // helpers
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("errors=%0d checks=%0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  // request held until waitrequest is seen low at a rising edge; only the bench timeout ends a hang
  task automatic bus(input logic wr, input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] d,
                     input logic [BE_W-1:0] be);
    @(posedge ref_clk_i);
    req <= '{read: !wr, write: wr, address: {idx, 2'b00}, writedata: d, byteenable: be};
    do begin
      @(posedge ref_clk_i);
    end while (wreq !== 1'b0);
    v = rdata;
    req <= '0;
  endtask : bus

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] d);
    bus(1'b1, idx, d, 4'hF);
  endtask : wr

  task automatic rdc(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] e);
    bus(1'b0, idx, '0, 4'hF);
    check(v, e);
  endtask : rdc

  task automatic settle;
    repeat (3) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask : settle

  // fl holds the flags of the sample sent by the previous call
  task automatic put(input logic vl, input logic [SMP_W-1:0] a, input logic [SMP_W-1:0] b);
    @(posedge ref_clk_i);
    smp_i <= '{valid: vl, i: a, q: b};
    @(negedge ref_clk_i);
    fl = flags;
  endtask : put

  // hit two samples into a period found from a falling flag: L-2 flagged samples follow
  task automatic meas(input logic [PER_W-1:0] f, output int cnt);
    logic prv;
    int n;
    wr(IDX_PERIOD, {29'h0, f});
    prv = 1'b0;
    cnt = 0;
    put(1'b1, 15'h4000, '0);
    for (n = 0; n < 100; n++) begin
      put(1'b1, '0, '0);
      if (prv === 1'b1 && fl[0] === 1'b0) break;
      prv = fl[0];
    end
    put(1'b1, 15'h4000, '0);
    put(1'b1, '0, '0);
    while (fl[0] === 1'b1 && cnt < 100) begin
      cnt++;
      put(1'b1, '0, '0);
    end
  endtask : meas

  // ----
  // sequence
  // ----
  initial begin
    repeat (4) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    rdc(IDX_LIMIT_I, 32'h0000_00F2);
    rdc(IDX_LIMIT_Q, 32'h0000_00AB);
    rdc(IDX_PERIOD, '0);
    rdc(IDX_SRC, '0);
    rdc(IDX_CHOICE, '0);
    rdc(IDX_DIV_LO, '0);
    rdc(IDX_DIV_HI, '0);
    wr(IDX_PERIOD, 32'hFFFF_FFFF);
    rdc(IDX_PERIOD, 32'h0000_0007);
    wr(IDX_CHOICE, 32'hFFFF_FFFF);
    rdc(IDX_CHOICE, 32'h0000_0007);
    wr(IDX_SRC, 32'hFFFF_FFFF);
    rdc(IDX_SRC, 32'h0000_0001);
    bus(1'b1, IDX_LIMIT_Q, 32'h0000_0011, 4'hE);
    rdc(IDX_LIMIT_Q, 32'h0000_00AB);
    wr(IDX_DIV_LO, 32'h0000_0034);
    wr(IDX_DIV_HI, 32'h0000_0012);
    rdc(IDX_DIV_HI, 32'h0000_0012);
    check(div, 32'h0000_1234);
    wr(10'h210, 32'hFFFF_FFFF);
    rdc(10'h210, '0);
    wr(IDX_W'(IDX_FREQ_BASE + 5), 32'h8765_4321);
    wr(IDX_W'(IDX_PHASE_BASE + 5), 32'hFFFF_BEEF);
    wr(IDX_W'(IDX_DLY_BASE + 5), 32'h0000_00F3);
    wr(IDX_SRC, '0);
    for (int p = 0; p < N_PRESET; p++) begin
      @(posedge ref_clk_i);
      pins <= p[PRESET_W-1:0];
      settle();
      check(act.index, p);
      check(act.freq, (p == 5) ? 32'h8765_4321 : RST_FREQ);
      check(act.phase, (p == 5) ? 32'h0000_BEEF : 32'h0000_0000);
      check(act.delay, (p == 5) ? 32'h0000_0003 : 32'h0000_0000);
    end
    wr(IDX_SRC, 32'h0000_0001);
    wr(IDX_CHOICE, 32'h0000_0003);
    settle();
    check(act.index, 32'h0000_0003);
    wr(IDX_CHOICE, 32'h0000_00FD);
    settle();
    check(act.freq, 32'h8765_4321);
    check(div, 32'h0000_1234);
    wr(IDX_LIMIT_I, 32'h0000_0040);
    wr(IDX_LIMIT_Q, 32'h0000_0080);
    wr(IDX_PERIOD, '0);
    repeat (6) put(1'b1, '0, '0);
    put(1'b1, 15'h0FFF, 15'h1FFF);
    put(1'b1, '0, '0);
    check(fl, 32'h0000_0000);
    put(1'b1, 15'h1000, 15'h2000);
    put(1'b1, '0, '0);
    check(fl, 32'h0000_0003);
    repeat (6) put(1'b1, '0, '0);
    put(1'b1, 15'h7000, 15'h6001);
    put(1'b1, '0, '0);
    check(fl, 32'h0000_0001);
    put(1'b1, 15'h4000, 15'h4000);
    repeat (5) put(1'b0, '0, '0);
    check(fl, 32'h0000_0003);
    @(posedge ref_clk_i);
    ce_i <= 1'b0;
    repeat (5) put(1'b1, '0, '0);
    check(fl, 32'h0000_0003);
    @(posedge ref_clk_i);
    ce_i <= 1'b1;
    meas(3'h1, ones);
    check(ones, (BP << 1) - 2);
    meas(3'h3, ones);
    check(ones, (BP << 3) - 2);
    report_and_stop();
  end
endmodule : orn_ctl_tb_top
